// File: pfm_pad_world.sv
`timescale 1ns/1ps
// pads and outside parties: request sources, tag source, card devices
module pfm_pad_world (
	// clock
	input wire logic core_clk,
	// device pad drive
	input wire logic [pfm_pkg::NUM_PINS-1:0] padOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] padOeN,
	input wire logic [2:0] portEPullup,
	// outside drivers set by the bench
	input wire logic [pfm_pkg::NUM_PINS-1:0] extVal,
	input wire logic [pfm_pkg::NUM_PINS-1:0] extOe,
	input wire logic [1:0] nmiSrc,
	input wire logic tagReq,
	// resolved pad levels
	output logic [pfm_pkg::NUM_PINS-1:0] padIn
);
	logic floatLvl_q = 1'b0; // undriven pins without pull-up wander
	logic [pfm_pkg::NUM_PINS-1:0] pullVec; // pull-up per flat pin
	assign pullVec = {{(pfm_pkg::NUM_PINS-3){1'b0}}, portEPullup};
	// floating level flips every cycle
	always_ff @(posedge core_clk) begin
		floatLvl_q <= !floatLvl_q;
	end
	// wire resolution: device, then outside party, then pull-up, else floating
	always_comb begin
		for (int i = 0; i < pfm_pkg::NUM_PINS; i++) begin
			padIn[i] = !padOeN[i] ? padOut[i] : extOe[i] ? extVal[i] :
				pullVec[i] ? 1'b1 : floatLvl_q;
		end
		// open-drain request sources, any one holds the line low
		if (|nmiSrc) padIn[pfm_pkg::PIN_E0] = 1'b0;
		// tag source pulls low whenever the device lets go of the pin
		if (tagReq && padOeN[pfm_pkg::PIN_E3]) padIn[pfm_pkg::PIN_E3] = 1'b0;
	end
endmodule

// File: pfm_pin_cell.sv
`timescale 1ns/1ps
// one shared pin: output select, registered pad drive and filtered input level
module pfm_pin_cell (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control from the mux
	input wire logic runEn,
	input wire logic funcSel,
	input wire logic funcOut,
	input wire logic funcOe,
	input wire logic gpioOut,
	input wire logic gpioDir,
	// pad side
	input wire logic padIn,
	output logic padOut,
	output logic padOeN,
	// filtered level seen by core and peripherals
	output logic level
);

	logic padOut_q, padOut_d; // registered pad output value
	logic padOeN_q, padOeN_d; // registered enable, low while driving
	logic [2:0] sync_q, sync_d; // three-stage input chain
	logic level_q, level_d; // accepted input level

	// next-state: the selected function owns the pin, otherwise gpio
	always_comb begin
		padOut_d = gpioOut;
		padOeN_d = ~gpioDir;
		if (funcSel) begin
			padOut_d = funcOut;
			padOeN_d = ~funcOe;
		end
		if (!runEn) begin
			// hold the pin as an undriven input until the mux is running
			padOut_d = 1'h0;
			padOeN_d = pfm_pkg::RST_OE_N;
		end
		sync_d = {sync_q[1:0], padIn};
		level_d = level_q;
		// first stage is read only by the second
		if (sync_q[1] == sync_q[2]) begin
			level_d = sync_q[2];
		end
	end

	// register stage
	always_ff @(posedge core_clk) begin
		// input chain keeps running through reset so a strap level is settled at release
		sync_q <= sync_d;
		if (!rst_n) begin
			padOut_q <= 1'h0;
			padOeN_q <= pfm_pkg::RST_OE_N;
			level_q <= 1'h1;
		end else begin
			padOut_q <= padOut_d;
			padOeN_q <= padOeN_d;
			level_q <= level_d;
		end
	end

	assign padOut = padOut_q;
	assign padOeN = padOeN_q;
	assign level = level_q;

endmodule

// File: pfm_pkg.sv
package pfm_pkg;

	// flat pin numbering shared by every per-pin vector of the block
	localparam int NUM_PINS = 23;
	localparam int PIN_E0 = 0; // port_e_bit0, nonmaskable_request input
	localparam int PIN_E2 = 1; // port_e_bit2, read/write direction
	localparam int PIN_E3 = 2; // port_e_bit3, low_byte_strobe / tag_low_input
	localparam int PIN_J0 = 3; // flash_card_io_write / disk io write / nand_card_address_latch
	localparam int PIN_J1 = 4; // flash_card_chip_enable1 / disk select 0 / nand_card_command_latch
	localparam int PIN_J2 = 5; // port_j_bit2: enable2 / disk_chip_select1 / write protect
	localparam int PIN_M3 = 6; // secure data1, capture ch2, flash_card_present, nand chip enable
	localparam int PIN_M4 = 7; // secure data2, capture ch3, flash_card_io16, nand_card_busy
	localparam int PIN_Q0 = 8; // port q bits 0..7 occupy 8..15
	localparam int PIN_Q3 = 11; // disk_io_read / flash_card_io_read / nand data3
	localparam int PIN_Q4 = 12; // capture ch4, flash addr4, nand data4, disk_dma_ack
	localparam int PIN_Q5 = 13; // capture ch5, secure_card_command, flash addr5, nand data5
	localparam int PIN_Q6 = 14; // capture ch6, secure_card_clock, flash addr6, nand data6
	localparam int PIN_Q7 = 15; // capture_channel7, flash addr7, nand data7
	localparam int PIN_S4 = 16; // serial receive
	localparam int PIN_S5 = 17; // serial transmit
	localparam int PIN_S6 = 18; // stick_card_clock / disk_dma_request / flash_card_write_enable
	localparam int PIN_S7 = 19; // stick_card_serial_data / disk_interrupt / flash ready
	localparam int PIN_T0 = 20; // capture ch0, secure data0, nand_card_read_enable, reg select
	localparam int PIN_T1 = 21; // capture ch1, secure data3, nand_card_write_enable, output enable
	localparam int PIN_U0 = 22; // flash_card_wait / disk_io_ready / nand_card_detect

	// pins that each function owner may claim
	localparam logic [NUM_PINS-1:0] FLASH_PINS = 23'h7cfff8;
	localparam logic [NUM_PINS-1:0] DISK_PINS = 23'h4c1f38;
	localparam logic [NUM_PINS-1:0] NAND_PINS = 23'h70fff8;
	localparam logic [NUM_PINS-1:0] SECURE_PINS = 23'h3060c0;
	localparam logic [NUM_PINS-1:0] STICK_PINS = 23'h0c0000;

	// capture-timer channel to pin map, channel 0 first
	localparam int TIMER_CHANNELS = 8;
	localparam int TIMER_PIN [TIMER_CHANNELS] = '{PIN_T0, PIN_T1, PIN_M3, PIN_M4,
		PIN_Q4, PIN_Q5, PIN_Q6, PIN_Q7};

	// operating mode codes as latched from the mode pins
	localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
	localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
	localparam logic [2:0] MODE_SPECIAL_WIDE = 3'h2;
	localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
	localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
	localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
	localparam logic [2:0] MODE_PERIPHERAL = 3'h6;
	localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

	// card host selection for the shared card pins
	typedef enum logic [1:0] {
		HOST_NONE,
		HOST_FLASH,
		HOST_DISK,
		HOST_NAND
	} pfm_host_e;

	// values after reset
	localparam logic RST_X_MASK = 1'h1;
	localparam logic RST_ROM_ENABLE = 1'h0;
	localparam logic RST_BUS_CLK = 1'h0;
	localparam logic RST_PULLUP = 1'h1;
	localparam logic RST_OE_N = 1'h1;

endpackage

// File: pfm_port_mux.sv
`timescale 1ns/1ps
// Function
// R01: port_e_bit3 resets to pulled-up gpio input
// R02: low_byte_strobe drives only after enable bit
// R03: tag modes share port_e_bit3 strobe and tag
// R04: tag low sampled at bus clock fall
// R05: port_e_bit2 resets to pulled-up gpio input
// R06: read/write drives only after enable bit
// R07: port_e_bit0 always input, always readable
// R08: reset sets X mask; request ignored until cleared
// R09: nonmaskable request is level sensitive, wired-OR
// R10: port E pull-ups on in reset, enable-controlled
// R11: port_j_bit2 latched to rom enable at release; only external bus modes latch it, other modes keep rom enable at 0
// R12: ports J,M,Q,S,T,U undriven through reset
// R13: port J routed to flash, disk or nand
// R14: port M routed to secure, timer, flash, nand
// R15: port Q 7,4 to timer, flash, nand, dma
// R16: port Q 6,5 routed timer, secure, flash, nand
// R17: port Q 3..0 routed disk, flash, nand
// R18: port S 7,6 routed stick, disk, flash
// R19: serial unit takes port S 5 and 4
// R20: port T routed timer, secure, nand, flash
// R21: port U 0 routed flash, disk, nand
// R22: bus clock output provided for external demux
// R23: one driver per pin, gpio fallback
module pfm_port_mux (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// operating mode and software controls
	input wire logic [2:0] opMode,
	input wire logic lowStrobeEnable,
	input wire logic readWriteEnable,
	input wire logic tagEnable,
	input wire logic portEPullupEnable,
	input wire logic xMaskClear,
	input wire pfm_pkg::pfm_host_e hostSel,
	input wire logic [pfm_pkg::TIMER_CHANNELS-1:0] timerEnable,
	input wire logic secureEnable,
	input wire logic stickEnable,
	input wire logic serialEnable,
	// core bus strobes
	input wire logic busLowStrobe,
	input wire logic busReadWrite,
	// general purpose port data and direction
	input wire logic [pfm_pkg::NUM_PINS-1:0] gpioOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] gpioDir,
	// peripheral drive requests, indexed by flat pin number
	input wire logic [pfm_pkg::NUM_PINS-1:0] flashOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] flashOe,
	input wire logic [pfm_pkg::NUM_PINS-1:0] diskOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] diskOe,
	input wire logic [pfm_pkg::NUM_PINS-1:0] nandOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] nandOe,
	input wire logic [pfm_pkg::NUM_PINS-1:0] secureOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] secureOe,
	input wire logic [pfm_pkg::NUM_PINS-1:0] stickOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] stickOe,
	// capture timer channels, channel numbered
	input wire logic [pfm_pkg::TIMER_CHANNELS-1:0] timerOut,
	input wire logic [pfm_pkg::TIMER_CHANNELS-1:0] timerOe,
	// serial transmit data
	input wire logic serialTxd,
	// pads
	input wire logic [pfm_pkg::NUM_PINS-1:0] padIn,
	output logic [pfm_pkg::NUM_PINS-1:0] padOut,
	output logic [pfm_pkg::NUM_PINS-1:0] padOeN,
	output logic [2:0] portEPullup,
	output logic busClockOut,
	// state seen by core and peripherals
	output logic [pfm_pkg::NUM_PINS-1:0] pinLevel,
	output logic serialRxd,
	output logic nmiRequest,
	output logic xMask,
	output logic tagLowByte,
	output logic romEnable
);

	// reset phase sequence: pins stay undriven until running
	typedef enum logic [1:0] {
		PH_RESET,
		PH_CAPTURE,
		PH_RUN
	} pfm_phase_e;

	pfm_phase_e phase_q, phase_d; // current reset phase
	logic busClk_q, busClk_d; // divided bus clock
	logic xMask_q, xMask_d; // interrupt mask bit
	logic nmi_q, nmi_d; // qualified nonmaskable request
	logic tagLow_q, tagLow_d; // tag pulse for the low byte
	logic rom_q, rom_d; // internal rom enable bit
	logic [2:0] pull_q, pull_d; // port E pull-up controls
	logic rxd_q, rxd_d; // serial receive level
	logic [pfm_pkg::NUM_PINS-1:0] levelVec; // filtered pin levels from the cells
	logic [pfm_pkg::NUM_PINS-1:0] funcSel; // a function owns the pin
	logic [pfm_pkg::NUM_PINS-1:0] funcOut; // selected function output
	logic [pfm_pkg::NUM_PINS-1:0] funcOe; // selected function drive
	logic [pfm_pkg::NUM_PINS-1:0] cellDir; // gpio direction after fixed-input pins
	logic runEn; // mux released from reset hold
	logic expanded; // an external bus mode
	logic tagMode; // strobe and tag share port_e_bit3
	logic busFall; // bus clock falls on this edge

	// mode decode
	always_comb begin
		expanded = 1'h1;
		tagMode = 1'h0;
		case (opMode)
			pfm_pkg::MODE_SPECIAL_SINGLE: expanded = 1'h0;
			pfm_pkg::MODE_NORMAL_SINGLE: expanded = 1'h0;
			pfm_pkg::MODE_PERIPHERAL: expanded = 1'h0;
			default: expanded = 1'h1;
		endcase
		// wide modes and emulation narrow carry tagging
		case (opMode)
			pfm_pkg::MODE_EMU_NARROW,
			pfm_pkg::MODE_SPECIAL_WIDE,
			pfm_pkg::MODE_EMU_WIDE,
			pfm_pkg::MODE_NORMAL_WIDE: tagMode = tagEnable; // [R03]
			default: tagMode = 1'h0;
		endcase
	end

	assign runEn = (phase_q == PH_RUN); // [R12]
	assign busFall = busClk_q & ~busClk_d;

	// per-pin function select with a fixed priority, so one driver wins
	always_comb begin
		funcSel = '0;
		funcOut = '0;
		funcOe = '0;
		cellDir = gpioDir;
		// port_e_bit0 is never driven
		cellDir[pfm_pkg::PIN_E0] = 1'h0; // [R07]
		// capture channels are the lowest priority function
		for (int c = 0; c < pfm_pkg::TIMER_CHANNELS; c++) begin
			if (timerEnable[c]) begin
				funcSel[pfm_pkg::TIMER_PIN[c]] = 1'h1; // [R14] [R15] [R16] [R20]
				funcOut[pfm_pkg::TIMER_PIN[c]] = timerOut[c];
				funcOe[pfm_pkg::TIMER_PIN[c]] = timerOe[c];
			end
		end
		for (int p = 0; p < pfm_pkg::NUM_PINS; p++) begin
			// stick card host above the timer
			if (stickEnable && pfm_pkg::STICK_PINS[p]) begin
				funcSel[p] = 1'h1; // [R18]
				funcOut[p] = stickOut[p];
				funcOe[p] = stickOe[p];
			end
			// secure card host
			if (secureEnable && pfm_pkg::SECURE_PINS[p]) begin
				funcSel[p] = 1'h1; // [R14] [R16] [R20]
				funcOut[p] = secureOut[p];
				funcOe[p] = secureOe[p];
			end
			// the one selected card host claims its pins
			case (hostSel)
				pfm_pkg::HOST_FLASH: begin
					if (pfm_pkg::FLASH_PINS[p]) begin
						funcSel[p] = 1'h1; // [R13] [R17] [R18] [R21]
						funcOut[p] = flashOut[p];
						funcOe[p] = flashOe[p];
					end
				end
				pfm_pkg::HOST_DISK: begin
					if (pfm_pkg::DISK_PINS[p]) begin
						funcSel[p] = 1'h1; // [R13] [R15] [R17] [R18] [R21]
						funcOut[p] = diskOut[p];
						funcOe[p] = diskOe[p];
					end
				end
				pfm_pkg::HOST_NAND: begin
					if (pfm_pkg::NAND_PINS[p]) begin
						funcSel[p] = 1'h1; // [R13] [R14] [R17] [R20] [R21]
						funcOut[p] = nandOut[p];
						funcOe[p] = nandOe[p];
					end
				end
				default: begin
					funcSel[p] = funcSel[p]; // [R23]
				end
			endcase
		end
		// serial unit: transmit driven, receive held as input
		if (serialEnable) begin
			funcSel[pfm_pkg::PIN_S5] = 1'h1; // [R19]
			funcOut[pfm_pkg::PIN_S5] = serialTxd;
			funcOe[pfm_pkg::PIN_S5] = 1'h1;
			funcSel[pfm_pkg::PIN_S4] = 1'h1; // [R19]
			funcOut[pfm_pkg::PIN_S4] = 1'h0;
			funcOe[pfm_pkg::PIN_S4] = 1'h0;
		end
		// read/write direction once enabled in an external bus mode
		if (readWriteEnable && expanded) begin
			funcSel[pfm_pkg::PIN_E2] = 1'h1; // [R06]
			funcOut[pfm_pkg::PIN_E2] = busReadWrite;
			funcOe[pfm_pkg::PIN_E2] = 1'h1;
		end
		// low strobe once enabled; in tag modes it is released while the
		// bus clock is high so the tag level can be sampled at the fall
		if (lowStrobeEnable && expanded) begin
			funcSel[pfm_pkg::PIN_E3] = 1'h1; // [R02]
			funcOut[pfm_pkg::PIN_E3] = busLowStrobe;
			funcOe[pfm_pkg::PIN_E3] = ~(tagMode & busClk_q); // [R03]
		end
	end

	// one cell per pin; unselected pins fall back to gpio
	for (genvar i = 0; i < pfm_pkg::NUM_PINS; i++) begin : g_pin
		pfm_pin_cell u_cell (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.runEn(runEn),
			.funcSel(funcSel[i]),
			.funcOut(funcOut[i]),
			.funcOe(funcOe[i]),
			.gpioOut(gpioOut[i]),
			.gpioDir(cellDir[i]),
			.padIn(padIn[i]),
			.padOut(padOut[i]),
			.padOeN(padOeN[i]),
			.level(levelVec[i])
		); // [R23]
	end

	// next-state for reset phase, clock, mask, tag and latched bits
	always_comb begin
		phase_d = phase_q;
		rom_d = rom_q;
		case (phase_q)
			PH_RESET: phase_d = PH_CAPTURE;
			PH_CAPTURE: begin
				// pin level has had the input chain's time to settle
				if (expanded) begin
					rom_d = levelVec[pfm_pkg::PIN_J2]; // [R11]
				end
				phase_d = PH_RUN;
			end
			PH_RUN: phase_d = PH_RUN;
			default: phase_d = PH_RESET;
		endcase
		// bus clock is half the core clock
		busClk_d = ~busClk_q; // [R22]
		// software clears the mask; only reset sets it
		xMask_d = xMask_q;
		if (xMaskClear) begin
			xMask_d = 1'h0; // [R08]
		end
		// level request, held as long as any wired source pulls low
		nmi_d = ~levelVec[pfm_pkg::PIN_E0] & ~xMask_q; // [R08] [R09]
		// tag pulse on the falling bus clock edge with the pin low
		tagLow_d = tagMode & busFall & ~levelVec[pfm_pkg::PIN_E3]; // [R04]
		// port E pull-ups forced on until running, then software decides
		pull_d = {3{portEPullupEnable}}; // [R10]
		if (!runEn) begin
			pull_d = {3{pfm_pkg::RST_PULLUP}}; // [R01] [R05] [R10]
		end
		// pull-up off on port_e_bit3 while the strobe drives it, and on port_e_bit2 while selected or set as gpio output
		if (funcSel[pfm_pkg::PIN_E3] && funcOe[pfm_pkg::PIN_E3] && runEn) begin
			pull_d[2] = 1'h0;
		end
		if (runEn && (funcSel[pfm_pkg::PIN_E2] || gpioDir[pfm_pkg::PIN_E2])) begin
			pull_d[1] = 1'h0;
		end
		rxd_d = levelVec[pfm_pkg::PIN_S4];
	end

	// register stage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_q <= PH_RESET;
			busClk_q <= pfm_pkg::RST_BUS_CLK;
			xMask_q <= pfm_pkg::RST_X_MASK; // [R08]
			nmi_q <= 1'h0;
			tagLow_q <= 1'h0;
			rom_q <= pfm_pkg::RST_ROM_ENABLE;
			pull_q <= {3{pfm_pkg::RST_PULLUP}};
			rxd_q <= 1'h1;
		end else begin
			phase_q <= phase_d;
			busClk_q <= busClk_d;
			xMask_q <= xMask_d;
			nmi_q <= nmi_d;
			tagLow_q <= tagLow_d;
			rom_q <= rom_d;
			pull_q <= pull_d;
			rxd_q <= rxd_d;
		end
	end

	// outputs straight from flip-flops
	assign portEPullup = pull_q;
	assign busClockOut = busClk_q;
	assign pinLevel = levelVec; // [R07]
	assign serialRxd = rxd_q;
	assign nmiRequest = nmi_q;
	assign xMask = xMask_q;
	assign tagLowByte = tagLow_q;
	assign romEnable = rom_q;

endmodule

// File: pfm_port_mux_properties.sv
`timescale 1ns/1ps
// pin ownership, reset and request relations seen at the mux ports
module pfm_mux_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// controls
	input wire logic [2:0] opMode,
	input wire logic lowStrobeEnable,
	input wire logic readWriteEnable,
	input wire logic tagEnable,
	input wire logic portEPullupEnable,
	input wire logic xMaskClear,
	input wire pfm_pkg::pfm_host_e hostSel,
	input wire logic busLowStrobe,
	input wire logic [pfm_pkg::NUM_PINS-1:0] gpioDir,
	input wire logic [pfm_pkg::NUM_PINS-1:0] flashOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] flashOe,
	// outputs
	input wire logic [pfm_pkg::NUM_PINS-1:0] padOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] padOeN,
	input wire logic [2:0] portEPullup,
	input wire logic busClockOut,
	input wire logic [pfm_pkg::NUM_PINS-1:0] pinLevel,
	input wire logic nmiRequest,
	input wire logic xMask,
	input wire logic tagLowByte,
	input wire logic romEnable
);
	localparam int E2 = pfm_pkg::PIN_E2; // read/write pin
	localparam int E3 = pfm_pkg::PIN_E3; // strobe and tag pin
	localparam int J0 = pfm_pkg::PIN_J0; // card write pin
	// edges since reset release, saturating at three
	logic [1:0] runCnt_q, runCnt_d;
	logic runOk; // pins are selectable from here on
	// next count
	always_comb begin
		runCnt_d = runCnt_q;
		if (!rst_n) begin
			runCnt_d = 2'h0;
		end else if (runCnt_q != 2'h3) begin
			runCnt_d = runCnt_q + 2'h1;
		end
	end
	// count register
	always_ff @(posedge core_clk) begin
		runCnt_q <= runCnt_d;
	end
	assign runOk = (runCnt_q == 2'h3);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// every pin stays undriven for three samples
	sequence floatHold;
		(&padOeN) [*3];
	endsequence
	// port E pull-ups stay on for three samples
	sequence pullHold;
		(portEPullup == 3'h7) [*3];
	endsequence
	chk_reset_float: assert property ($rose(rst_n) |-> floatHold)
		else $error("pin driven right after reset");
	chk_reset_pull: assert property ($rose(rst_n) |-> pullHold)
		else $error("port E pull-up off right after reset");
	chk_pull_off: assert property (runOk && !portEPullupEnable |=> !portEPullup[0])
		else $error("request pull-up not switched off");
	chk_e0_input: assert property (padOeN[pfm_pkg::PIN_E0])
		else $error("request pin driven");
	chk_strobe_gate: assert property (runOk && !lowStrobeEnable && !gpioDir[E3] |=> padOeN[E3])
		else $error("strobe pin driven while disabled");
	chk_rw_gate: assert property (runOk && !readWriteEnable && !gpioDir[E2] |=> padOeN[E2])
		else $error("read/write pin driven while disabled");
	chk_strobe_follow: assert property (runOk && lowStrobeEnable && !tagEnable &&
		opMode == pfm_pkg::MODE_NORMAL_NARROW |=> !padOeN[E3] && padOut[E3] == $past(busLowStrobe))
		else $error("strobe pin not following bus strobe");
	chk_mask_block: assert property (xMask |=> !nmiRequest)
		else $error("request passed while masked");
	chk_mask_sticky: assert property (!xMask |=> !xMask)
		else $error("mask set again without reset");
	chk_mask_hold: assert property (xMask && !xMaskClear |=> xMask)
		else $error("mask dropped without a clear");
	chk_nmi_level: assert property (!xMask |=> nmiRequest == !$past(pinLevel[pfm_pkg::PIN_E0]))
		else $error("request not following pin level");
	chk_tag_cause: assert property (tagLowByte |-> $past(busClockOut) && !$past(pinLevel[E3]) &&
		$past(tagEnable))
		else $error("tag without low level at clock fall");
	chk_bus_clock: assert property (runOk |-> busClockOut != $past(busClockOut))
		else $error("bus clock not toggling");
	chk_rom_steady: assert property (runOk |-> $stable(romEnable))
		else $error("rom enable changed after capture");
	chk_flash_route: assert property (runOk && hostSel == pfm_pkg::HOST_FLASH && flashOe[J0]
		|=> !padOeN[J0] && padOut[J0] == $past(flashOut[J0]))
		else $error("card write pin not routed");
endmodule

// File: pfm_port_mux_tb.sv
`timescale 1ns/1ps
// attach the port checker to the mux
bind pfm_port_mux pfm_mux_checker chk (.core_clk, .rst_n, .opMode, .lowStrobeEnable,
	.readWriteEnable, .tagEnable, .portEPullupEnable, .xMaskClear, .hostSel, .busLowStrobe,
	.gpioDir, .flashOut, .flashOe, .padOut, .padOeN, .portEPullup, .busClockOut, .pinLevel,
	.nmiRequest, .xMask, .tagLowByte, .romEnable);
// compare and count
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module pfm_port_mux_tb;
	localparam int NP = pfm_pkg::NUM_PINS;
	localparam int E3 = pfm_pkg::PIN_E3;
	// clock, reset and controls
	logic core_clk = 1'b0, rst_n = 1'b0;
	logic [2:0] opMode = 3'h5;
	logic lowStrobeEnable = 1'b0, readWriteEnable = 1'b0, tagEnable = 1'b0, tagReq = 1'b0;
	logic portEPullupEnable = 1'b1, xMaskClear = 1'b0, serialTxd = 1'b0;
	logic secureEnable = 1'b0, stickEnable = 1'b0, serialEnable = 1'b0;
	logic busLowStrobe = 1'b1, busReadWrite = 1'b1;
	pfm_pkg::pfm_host_e hostSel = pfm_pkg::HOST_NONE;
	logic [7:0] timerEnable = 8'h00, timerOut = 8'ha5, timerOe = 8'h00;
	logic [1:0] nmiSrc = 2'h0;
	// per-pin vectors
	logic [NP-1:0] gpioOut = '0, gpioDir = '0, flashOut = '0, flashOe = '0, diskOut = '0;
	logic [NP-1:0] diskOe = '0, nandOut = '0, nandOe = '0, secureOut = '0, secureOe = '0;
	logic [NP-1:0] stickOut = '0, stickOe = '0, extVal = '0, extOe = '0;
	// design outputs
	logic [NP-1:0] padIn, padOut, padOeN, pinLevel;
	logic [2:0] portEPullup;
	logic busClockOut, serialRxd, nmiRequest, xMask, tagLowByte, romEnable;
	int err_total = 0, checked = 0, hits, flt;
	always #25 core_clk = !core_clk;
	pfm_port_mux dut (.core_clk, .rst_n, .opMode, .lowStrobeEnable, .readWriteEnable,
		.tagEnable, .portEPullupEnable, .xMaskClear, .hostSel, .timerEnable, .secureEnable,
		.stickEnable, .serialEnable, .busLowStrobe, .busReadWrite, .gpioOut, .gpioDir,
		.flashOut, .flashOe, .diskOut, .diskOe, .nandOut, .nandOe, .secureOut, .secureOe,
		.stickOut, .stickOe, .timerOut, .timerOe, .serialTxd, .padIn, .padOut, .padOeN,
		.portEPullup, .busClockOut, .pinLevel, .serialRxd, .nmiRequest, .xMask, .tagLowByte,
		.romEnable);
	pfm_pad_world world (.core_clk, .padOut, .padOeN, .portEPullup, .extVal, .extOe, .nmiSrc,
		.tagReq, .padIn);
	// let n edges pass, then step just off the edge
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// counts, verdict and end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// reset with a held rom-select level, checks around the release
	task automatic do_reset(input logic [2:0] mode, input logic j2, input logic romExp);
		rst_n = 1'b0;
		opMode = mode;
		extOe[pfm_pkg::PIN_J2] = 1'b1;
		extVal[pfm_pkg::PIN_J2] = j2;
		step(12);
		`CHK(padOeN, {NP{1'b1}})
		`CHK(xMask, 1'b1)
		rst_n = 1'b1;
		step(2);
		`CHK(padOeN, {NP{1'b1}})
		`CHK(portEPullup, 3'h7)
		step(3);
		`CHK(romEnable, romExp)
		extOe[pfm_pkg::PIN_J2] = 1'b0;
	endtask
	// masked pins must be driven with the pattern
	task automatic expect_drive(input logic [NP-1:0] mask, input logic [NP-1:0] pat);
		step(2);
		`CHK(padOeN & mask, {NP{1'b0}})
		`CHK(padOut & mask, pat & mask)
	endtask
	// watch the tag pin for forty cycles
	task automatic tag_window();
		hits = 0;
		flt = 0;
		repeat (40) begin
			step(1);
			if (tagLowByte === 1'b1) hits++;
			if (padOeN[E3] === 1'b1) flt++;
		end
	endtask
	// cut a hang short
	initial begin
		#2ms;
		err_total++;
		give_verdict();
	end
	// main sequence
	initial begin
		gpioDir = 23'h7ffff8;
		gpioOut = 23'h5a5a5a;
		hostSel = pfm_pkg::HOST_FLASH;
		flashOe = '1;
		flashOut = 23'h3c3c3c;
		do_reset(pfm_pkg::MODE_NORMAL_SINGLE, 1'b1, 1'b0);
		do_reset(pfm_pkg::MODE_NORMAL_WIDE, 1'b0, 1'b0);
		do_reset(pfm_pkg::MODE_NORMAL_NARROW, 1'b1, 1'b1);
		// card hosts over a busy timer
		timerEnable = 8'hff;
		timerOe = 8'hff;
		diskOe = '1;
		nandOe = '1;
		diskOut = 23'h0f0f0f;
		nandOut = 23'h71c71c;
		expect_drive(pfm_pkg::FLASH_PINS, flashOut);
		hostSel = pfm_pkg::HOST_DISK;
		expect_drive(pfm_pkg::DISK_PINS, diskOut);
		hostSel = pfm_pkg::HOST_NAND;
		expect_drive(pfm_pkg::NAND_PINS, nandOut);
		// secure and stick cards, then the timer alone, then gpio
		hostSel = pfm_pkg::HOST_NONE;
		secureEnable = 1'b1;
		stickEnable = 1'b1;
		secureOe = '1;
		stickOe = '1;
		secureOut = 23'h2aaaaa;
		stickOut = 23'h155555;
		expect_drive(pfm_pkg::SECURE_PINS, secureOut);
		expect_drive(pfm_pkg::STICK_PINS, stickOut);
		secureEnable = 1'b0;
		stickEnable = 1'b0;
		step(2);
		for (int i = 0; i < 8; i++) begin
			`CHK(padOut[pfm_pkg::TIMER_PIN[i]], timerOut[i])
		end
		timerEnable = 8'h00;
		expect_drive(23'h7ffff8, gpioOut);
		// serial unit takes S5 and S4 over gpio
		serialEnable = 1'b1;
		serialTxd = 1'b1;
		extOe[pfm_pkg::PIN_S4] = 1'b1;
		extVal[pfm_pkg::PIN_S4] = 1'b0;
		step(6);
		`CHK({padOeN[pfm_pkg::PIN_S4], padOeN[pfm_pkg::PIN_S5]}, 2'h2)
		`CHK({padOut[pfm_pkg::PIN_S5], serialRxd}, 2'h2)
		// bus strobe and read/write only once enabled
		step(2);
		`CHK(padOeN[2:1], 2'h3)
		lowStrobeEnable = 1'b1;
		readWriteEnable = 1'b1;
		busLowStrobe = 1'b0;
		step(2);
		`CHK({padOeN[2:1], padOut[2:1]}, 4'h1)
		portEPullupEnable = 1'b0;
		step(2);
		`CHK(portEPullup[0], 1'b0)
		portEPullupEnable = 1'b1;
		// masked, then shared level request
		nmiSrc = 2'h1;
		step(6);
		`CHK({pinLevel[0], nmiRequest}, 2'h0)
		xMaskClear = 1'b1;
		step(1);
		xMaskClear = 1'b0;
		nmiSrc = 2'h2;
		step(6);
		`CHK({xMask, nmiRequest}, 2'h1)
		nmiSrc = 2'h0;
		step(6);
		`CHK(nmiRequest, 1'b0)
		// tag sharing of the strobe pin
		opMode = pfm_pkg::MODE_EMU_WIDE;
		tagEnable = 1'b1;
		tagReq = 1'b1;
		tag_window();
		`CHK(hits > 0, 1'b1)
		`CHK(flt > 0 && flt < 40, 1'b1)
		tagEnable = 1'b0;
		step(2);
		tag_window();
		`CHK(hits, 0)
		give_verdict();
	end
endmodule
